// *** pkg/apwk_pkg.sv ***
// Package for the asynchronous partial wakeup clock controller.
// Assumes a 32-bit APB slave on pclk at 50 MHz.
package apwk_pkg;

    // Register byte offsets
    localparam logic [7:0] APWK_PCER_OFF  = 8'h00;  // periph_clock_enable_reg, write-one-to-set
    localparam logic [7:0] APWK_PCDR_OFF  = 8'h04;  // peripheral clock disable, write-one-to-clear
    localparam logic [7:0] APWK_PCSR_OFF  = 8'h08;  // periph_clock_status_reg, read
    localparam logic [7:0] APWK_PWER_OFF  = 8'h0C;  // partial_wakeup_enable_reg, write-one-to-set
    localparam logic [7:0] APWK_PWDR_OFF  = 8'h10;  // partial_wakeup_disable_reg, write-one-to-clear
    localparam logic [7:0] APWK_PWSR_OFF  = 8'h14;  // partial wakeup enable status, read
    localparam logic [7:0] APWK_ASR_OFF   = 8'h18;  // partial_wakeup_activity_status, read
    localparam logic [7:0] APWK_AIPR_OFF  = 8'h1C;  // activity_in_progress_reg, read
    localparam logic [7:0] APWK_WAIT_OFF  = 8'h20;  // write bit 0 = 1 to enter Wait mode
    localparam logic [7:0] APWK_STAT_OFF  = 8'h24;  // controller state, read

    // Field positions
    localparam int APWK_AIP_BIT       = 0;
    localparam int APWK_WAIT_GO_BIT   = 0;
    localparam int APWK_STAT_WAIT_BIT = 0;
    localparam int APWK_STAT_SYS_BIT  = 1;

    // Reset values
    localparam logic [31:0] APWK_PCSR_RST = 32'h0000_0000;
    localparam logic [31:0] APWK_PWSR_RST = 32'h0000_0000;

    // Peripherals able to do partial wakeup: UART and two_wire_hs_port identifiers
    localparam logic [31:0] APWK_CAPABLE_DEF = 32'h0000_0F1C;

    localparam int APWK_NPER_MAX = 32;

    typedef enum logic {
        APWK_RUN,
        APWK_WAIT
    } apwk_state_t;

    // Synchronised per-peripheral request levels
    typedef struct packed {
        logic clk_req;
        logic active;
        logic wake;
    } apwk_req_t;

endpackage

// *** src/apwk_slice.sv ***
// One peripheral's request synchroniser and clock gate decision.
// Assumes the request pins are asynchronous to pclk.
`timescale 1ns/1ps
module apwk_slice (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Asynchronous requests from the peripheral
    input  wire logic               clk_req_a,
    input  wire logic               active_a,
    input  wire logic               wake_a,
    // Controller state
    input  wire logic               in_wait,
    input  wire logic               clk_on,
    input  wire logic               pwk_on,
    // Results
    output apwk_pkg::apwk_req_t     req,
    output logic                    clk_en_next
);
    import apwk_pkg::*;

    apwk_req_t meta_reg;
    apwk_req_t sync_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= '{clk_req: clk_req_a, active: active_a, wake: wake_a};
            sync_reg <= meta_reg;
        end
    end

    assign req = sync_reg;

    // In Wait mode only a requesting enabled peripheral is clocked
    wire logic wait_clk = pwk_on & sync_reg.clk_req;
    // Running: clock stops once partial wakeup is armed and idle
    wire logic run_clk  = clk_on & ~(pwk_on & ~sync_reg.active);

    assign clk_en_next = in_wait ? wait_clk : run_clk;

endmodule // apwk_slice

// *** src/apwk_ctrl.sv ***
// Asynchronous partial wakeup clock controller with APB register access.
// Assumes peripheral request pins are asynchronous; clock enables drive gates elsewhere.
//
// Summary of operation
// - Only UART and two-wire ports may arm
// - Wait mode stops all but slow clock
// - Clock request clocks only that peripheral
// - Peripheral wakes system or clock stops again
// - Wakeup request clears partial-wakeup enables
// - Enable and disable registers write-one
// - Armed and idle: peripheral clock stops
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module apwk_ctrl #(
    parameter int          NPER    = 32,
    parameter logic [31:0] CAPABLE = apwk_pkg::APWK_CAPABLE_DEF
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Peripheral requests, asynchronous
    input  wire logic [NPER-1:0]    clk_req,
    input  wire logic [NPER-1:0]    periph_active,
    input  wire logic [NPER-1:0]    wake_req,
    input  wire logic               ext_wake,
    // Clock control outputs
    output logic [NPER-1:0]         periph_clk_en,
    output logic                    sys_clk_en,
    output logic                    in_wait
);
    import apwk_pkg::*;

    generate
        if (NPER < 1 || NPER > APWK_NPER_MAX) begin : g_chk
            $error("apwk_ctrl: NPER must be 1 to 32");
        end
    endgenerate

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr[7:2] == off[7:2]);
    endfunction

    // Registers
    apwk_state_t      state_reg,  state_next;
    logic [NPER-1:0]  pcsr_reg,   pcsr_next;
    logic [NPER-1:0]  pwk_reg,    pwk_next;
    logic [NPER-1:0]  clk_en_reg;
    logic [31:0]      prdata_reg;
    logic             pready_reg;
    logic             pslverr_reg;
    logic             sys_reg;
    logic             wait_reg;
    logic [1:0]       ext_sync_reg;

    // Synchronised peripheral levels
    apwk_req_t        req [NPER];
    logic [NPER-1:0]  clk_en_next;
    logic [NPER-1:0]  act_s;
    logic [NPER-1:0]  wake_s;

    wire logic in_wait_now = (state_reg == APWK_WAIT);

    genvar gi;
    generate
        for (gi = 0; gi < NPER; gi++) begin : g_per
            apwk_slice u_slice (
                .pclk        (pclk),
                .presetn     (presetn),
                .clk_req_a   (clk_req[gi]),
                .active_a    (periph_active[gi]),
                .wake_a      (wake_req[gi]),
                .in_wait     (in_wait_now),
                .clk_on      (pcsr_reg[gi]),
                .pwk_on      (pwk_reg[gi]),
                .req         (req[gi]),
                .clk_en_next (clk_en_next[gi])
            );
            assign act_s[gi]  = req[gi].active;
            assign wake_s[gi] = req[gi].wake;
        end
    endgenerate

    // APB decode
    wire logic        acc     = psel & penable & ~pready_reg;
    wire logic        wr      = acc & pwrite;
    wire logic        rd      = acc & ~pwrite;
    wire logic [31:0] wmask   = (NPER == 32) ? 32'hFFFF_FFFF : ((32'h1 << NPER) - 32'h1);
    wire logic [NPER-1:0] wbits = pwdata[NPER-1:0];
    wire logic [NPER-1:0] cap   = CAPABLE[NPER-1:0];

    wire logic wr_pcer = wr & hit(paddr, APWK_PCER_OFF);
    wire logic wr_pcdr = wr & hit(paddr, APWK_PCDR_OFF);
    wire logic wr_pwer = wr & hit(paddr, APWK_PWER_OFF);
    wire logic wr_pwdr = wr & hit(paddr, APWK_PWDR_OFF);
    wire logic wr_wait = wr & hit(paddr, APWK_WAIT_OFF) & pwdata[APWK_WAIT_GO_BIT];

    wire logic mapped = hit(paddr, APWK_PCER_OFF) | hit(paddr, APWK_PCDR_OFF)
                      | hit(paddr, APWK_PCSR_OFF) | hit(paddr, APWK_PWER_OFF)
                      | hit(paddr, APWK_PWDR_OFF) | hit(paddr, APWK_PWSR_OFF)
                      | hit(paddr, APWK_ASR_OFF)  | hit(paddr, APWK_AIPR_OFF)
                      | hit(paddr, APWK_WAIT_OFF) | hit(paddr, APWK_STAT_OFF);
    wire logic ro_hit = hit(paddr, APWK_PCSR_OFF) | hit(paddr, APWK_PWSR_OFF)
                      | hit(paddr, APWK_ASR_OFF)  | hit(paddr, APWK_AIPR_OFF)
                      | hit(paddr, APWK_STAT_OFF);

    // Activity seen only on armed peripherals counts as partial wakeup activity
    wire logic [NPER-1:0] asr = act_s & pwk_reg;
    wire logic            any_activity_flag = |asr;

    // Any wakeup from a clocked armed peripheral, or from outside
    wire logic pwk_wake = |(wake_s & pwk_reg & clk_en_reg);
    wire logic wakeup   = pwk_wake | ext_sync_reg[1];

    // Read mux
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit(paddr, APWK_PCSR_OFF)) begin
            rd_data[NPER-1:0] = pcsr_reg;
        end
        if (hit(paddr, APWK_PWSR_OFF)) begin
            rd_data[NPER-1:0] = pwk_reg;
        end
        if (hit(paddr, APWK_ASR_OFF)) begin
            rd_data[NPER-1:0] = asr;
        end
        if (hit(paddr, APWK_AIPR_OFF)) begin
            rd_data[APWK_AIP_BIT] = any_activity_flag;
        end
        if (hit(paddr, APWK_STAT_OFF)) begin
            rd_data[APWK_STAT_WAIT_BIT] = in_wait_now;
            rd_data[APWK_STAT_SYS_BIT]  = sys_reg;
        end
        rd_data = rd_data & wmask | (hit(paddr, APWK_AIPR_OFF) | hit(paddr, APWK_STAT_OFF) ? rd_data : 32'h0);
    end

    // Peripheral clock status
    always_comb begin
        pcsr_next = pcsr_reg;
        if (wr_pcdr) begin
            pcsr_next = pcsr_next & ~wbits;
        end
        if (wr_pcer) begin
            pcsr_next = pcsr_next | wbits;
        end
    end

    // Partial wakeup enables
    always_comb begin
        pwk_next = pwk_reg;
        if (wakeup) begin
            pwk_next = '0;
        end
        if (wr_pwdr) begin
            pwk_next = pwk_next & ~wbits;
        end
        if (wr_pwer) begin
            pwk_next = pwk_next | (wbits & cap);
        end
    end

    // Run / Wait state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            APWK_RUN: begin
                if (wr_wait && !wakeup) begin
                    state_next = APWK_WAIT;
                end
            end
            APWK_WAIT: begin
                if (wakeup) begin
                    state_next = APWK_RUN;
                end
            end
            default: state_next = APWK_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= APWK_RUN;
            pcsr_reg     <= APWK_PCSR_RST[NPER-1:0];
            pwk_reg      <= APWK_PWSR_RST[NPER-1:0];
            clk_en_reg   <= '0;
            ext_sync_reg <= 2'h0;
        end else begin
            state_reg    <= state_next;
            pcsr_reg     <= pcsr_next;
            pwk_reg      <= pwk_next;
            clk_en_reg   <= clk_en_next;
            ext_sync_reg <= {ext_sync_reg[0], ext_wake};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reg  <= 1'b1;
            wait_reg <= 1'b0;
        end else begin
            sys_reg  <= (state_next == APWK_RUN);
            wait_reg <= (state_next == APWK_WAIT);
        end
    end

    // APB answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= acc;
            pslverr_reg <= acc & (~mapped | (pwrite & ro_hit));
            prdata_reg  <= (rd & mapped) ? rd_data : 32'h0000_0000;
        end
    end

    assign prdata        = prdata_reg;
    assign pready        = pready_reg;
    assign pslverr       = pslverr_reg;
    assign periph_clk_en = clk_en_reg;
    assign sys_clk_en    = sys_reg;
    assign in_wait       = wait_reg;

endmodule // apwk_ctrl

// *** tb/apwk_monitor.sv ***
// Port checker for the partial wakeup clock controller.
// Assumes it is bound to apwk_ctrl and sees only its ports.
`timescale 1ns/1ps
module apwk_monitor #(
    parameter int          NPER    = 32,
    parameter logic [31:0] CAPABLE = 32'h0000_0F1C
) (
    // Clock and reset
    input wire logic            pclk,
    input wire logic            presetn,
    // APB
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    // Peripheral side
    input wire logic [NPER-1:0] clk_req,
    input wire logic [NPER-1:0] periph_active,
    input wire logic [NPER-1:0] wake_req,
    input wire logic            ext_wake,
    input wire logic [NPER-1:0] periph_clk_en,
    input wire logic            sys_clk_en,
    input wire logic            in_wait
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wait_wr = psel && penable && pwrite && paddr[7:2] == 6'h08 && pwdata[0];

    wait_gate_a: assert property (sys_clk_en == !in_wait)
        else $error("system clock runs in wait");
    wait_cause_a: assert property ($rose(in_wait) |-> $past(wait_wr, 1) || $past(wait_wr, 2))
        else $error("wait entered without a wait write");
    capable_only_a: assert property (in_wait && $past(in_wait) |-> (periph_clk_en & ~CAPABLE[NPER-1:0]) == '0)
        else $error("clock given to a peripheral that cannot wake partially");
    req_only_a: assert property (in_wait && $past(in_wait, 4)
        |-> (periph_clk_en & ~($past(clk_req, 2) | $past(clk_req, 3) | $past(clk_req, 4))) == '0)
        else $error("clock given without a request");
    // Wakeup passes a two-stage synchroniser, so Wait ends within three edges
    wake_exit_a: assert property (in_wait && ((wake_req & periph_clk_en) != '0) |-> ##[1:3] !in_wait)
        else $error("peripheral wakeup ignored");
    ext_exit_a: assert property (in_wait && ext_wake |-> ##[1:3] !in_wait)
        else $error("system wakeup ignored");
    bus_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    ro_refuse_a: assert property (pready && psel && pwrite && paddr[7:2] == 6'h02 |-> pslverr)
        else $error("write to clock status not refused");
endmodule // apwk_monitor

bind apwk_ctrl apwk_monitor #(.NPER(NPER), .CAPABLE(CAPABLE)) apwk_monitor_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .clk_req, .periph_active, .wake_req, .ext_wake,
    .periph_clk_en, .sys_clk_en, .in_wait);

// *** tb/apwk_periph.sv ***
// Model of peripherals that ask for their clock while the system waits.
// Assumes the bench pulses kick for one cycle per new request.
`timescale 1ns/1ps
module apwk_periph #(
    parameter int NPER = 32
) (
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // Bench controls
    input  wire logic [NPER-1:0] kick,
    input  wire logic [NPER-1:0] wake_on,
    // Controller side
    input  wire logic [NPER-1:0] clk_en,
    output logic      [NPER-1:0] clk_req,
    output logic      [NPER-1:0] wake_req
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_req  <= '0;
            wake_req <= '0;
        end else begin
            // A served request either asks for full wakeup or hands its clock back
            clk_req  <= kick | (clk_req & ~(clk_en & ~wake_on));
            wake_req <= clk_req & clk_en & wake_on;
        end
    end
endmodule // apwk_periph

// *** tb/testbench.sv ***
// Self-checking bench for the partial wakeup clock controller.
// Assumes default parameters and an APB master on pclk.
`timescale 1ns/1ps
module testbench;
    import apwk_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext_wake = 0, er;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, periph_active = '0, kick = '0, wake_on = '0, prdata, rd;
    logic [31:0] clk_req, wake_req, periph_clk_en;
    logic        pready, pslverr, sys_clk_en, in_wait;
    int          n_mismatch = 0, comparisons = 0;
    always #10 pclk = ~pclk;
    apwk_ctrl apwk_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .clk_req, .periph_active, .wake_req, .ext_wake, .periph_clk_en, .sys_clk_en, .in_wait);
    apwk_periph apwk_periph_i (.pclk, .presetn, .kick, .wake_on, .clk_en(periph_clk_en), .clk_req, .wake_req);

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Access phase is two edges long; a hang is caught by the watchdog
        chk("answer", 32'h2, 32'(k));
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        xfer(1'b0, a, 32'h0);
        chk(nm, ex, rd);
    endtask
    task automatic settle;
        repeat (10) @(posedge pclk);
    endtask
    task automatic pulse(input logic [31:0] m);
        @(posedge pclk);
        kick <= m;
        @(posedge pclk);
        kick <= '0;
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("status", APWK_PCSR_OFF, APWK_PCSR_RST);
        rdchk("state", APWK_STAT_OFF, 32'h2);
        xfer(1'b0, 8'h30, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        xfer(1'b1, APWK_PCSR_OFF, 32'hFFFF_FFFF);
        chk("read only", 32'h1, {31'h0, er});
        wr(APWK_PCER_OFF, 32'h0000_0FFF);
        wr(APWK_PWER_OFF, 32'hFFFF_FFFF);
        rdchk("capable", APWK_PWSR_OFF, APWK_CAPABLE_DEF);
        wr(APWK_PWDR_OFF, 32'hFFFF_FFFB);
        rdchk("armed", APWK_PWSR_OFF, 32'h4);
        rdchk("clock on", APWK_PCSR_OFF, 32'h0000_0FFF);
        rdchk("idle", APWK_ASR_OFF, 32'h0);
        settle;
        chk("gates", 32'h0000_0FFB, periph_clk_en);
        periph_active <= 32'h8;
        wr(APWK_PWER_OFF, 32'h8);
        settle;
        rdchk("busy", APWK_ASR_OFF, 32'h8);
        rdchk("any busy", APWK_AIPR_OFF, 32'h1);
        chk("busy gate", 32'h0000_0FFB, periph_clk_en);
        wr(APWK_PWDR_OFF, 32'h8);
        periph_active <= '0;
        settle;
        rdchk("none busy", APWK_AIPR_OFF, 32'h0);
        wr(APWK_WAIT_OFF, 32'h1);
        rdchk("waiting", APWK_STAT_OFF, 32'h1);
        chk("all off", 32'h0, periph_clk_en);
        // Of the two requesting peripherals only the armed one, bit 2, is clocked
        pulse(32'h24);
        // The served clock stands four edges, from the fourth to the eighth after the request
        repeat (5) @(posedge pclk);
        chk("partial", 32'h4, periph_clk_en);
        settle;
        chk("given back", 32'h0, periph_clk_en);
        chk("still wait", 32'h1, {31'h0, in_wait});
        wake_on <= 32'h4;
        pulse(32'h4);
        settle;
        chk("woken", 32'h1, {31'h0, sys_clk_en});
        rdchk("disarmed", APWK_PWSR_OFF, 32'h0);
        wake_on <= '0;
        settle;
        wr(APWK_PWER_OFF, 32'h4);
        wr(APWK_WAIT_OFF, 32'h1);
        ext_wake <= 1'b1;
        settle;
        chk("ext woken", 32'h0, {31'h0, in_wait});
        rdchk("ext disarmed", APWK_PWSR_OFF, 32'h0);
        ext_wake <= 1'b0;
        close_out;
    end
    initial begin
        #100000;
        n_mismatch++;
        close_out;
    end
endmodule // testbench
